// [core/irq_ctrl.sv]
/*
  Interrupt enable, priority and extended flag registers of the core, with the
  priority-qualified requests and the preemption hint handed to the core.
  Assumes the core presents rd_addr one cycle before it takes rd_data and
  writes registers with a one-cycle strobe; all inputs are synchronous to clk.
  Peripherals hold their request levels until their own flags are cleared.
*/
// Summary of operation
// RULE1: Global gate low masks everything except the resume wakeup request.
// RULE2: Serial port 1 request passes only with its enable set.
// RULE3: Without extended unit, serial 1 enable and priority bits read zero.
// RULE4: Enables and priorities of absent peripherals stay as storage, no effect.
// RULE5: Timer 2 overflow or external flag passes only with timer 2 enable.
// RULE6: Serial port 0 transmit or receive passes only with its enable.
// RULE7: Timer 1 and timer 0 overflow requests gated by their enables.
// RULE8: External pin 1 and pin 0 requests gated by their enables.
// RULE9: Priority top bit and flag bit 3 read one, flag bits 2..0 zero.
// RULE10: Serial 1, timer 2, serial 0 priority bit selects high or low.
// RULE11: Timer 1, pin 1, timer 0, pin 0 priority bit selects high or low.
// RULE12: Falling edge on active-low pin 5 sets its flag.
// RULE13: Rising edge on pin 4 sets its flag.
// RULE14: Two-wire controller request sets the two-wire flag.
// RULE15: USB request sets the USB flag, held until software clears it.
// RULE16: Edge flags are never cleared by hardware; software writes zero.
// RULE17: Writing one to an extended flag raises it like a hardware event.
// RULE18: USB requests pass only with the extended USB enable set.
// RULE19: A running routine is preempted only by strictly higher priority, or by resume.
// RULE20: Request equals flag AND own enable AND global gate, resume exempt.
`timescale 1ns/10ps
`include "irq_ctrl_params.svh"

module irq_ctrl
  import irq_ctrl_pkg::*;
#(
  parameter bit EXT_INTR    = 1'b1,
  parameter bit HAS_SERIAL0 = 1'b1,
  parameter bit HAS_SERIAL1 = 1'b1,
  parameter bit HAS_TIMER2  = 1'b1
)(
  // Clock and reset.
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  // Register access.
  input  wire sfr_wr_t              sfr_wr,
  input  wire logic [7:0]           rd_addr,
  output logic [7:0]                rd_data,
  // Request sources.
  input  wire periph_req_t          periph_req,
  input  wire logic                 irq_pin5_n,
  input  wire logic                 irq_pin4,
  input  wire logic                 two_wire_req,
  input  wire logic                 usb_req,
  input  wire logic                 resume_req,
  // Core handshake: set on vector entry, cleared on return.
  input  wire logic                 enter_high,
  input  wire logic                 enter_low,
  input  wire logic                 return_done,
  // Requests to the core.
  output logic [`NUM_REQ-1:0]       req_high,
  output logic [`NUM_REQ-1:0]       req_low,
  output logic                      preempt_req
);

  // One-hot service levels of the routine the core is running.
  typedef enum logic [2:0] {
    LVL_IDLE = 3'b001,
    LVL_LOW  = 3'b010,
    LVL_HIGH = 3'b100
  } level_t;

  logic [7:0]           en_main_reg;
  logic [7:0]           prio_main_reg;
  logic [7:0]           ext_en_reg;
  logic [7:0]           ext_prio_reg;
  logic [7:0]           ext_ctrl_reg;
  logic [7:0]           ext_flags_reg;
  logic [7:0]           ext_flags_next;
  logic                 pin5_last_reg;
  logic                 pin4_last_reg;
  logic [`NUM_REQ-1:0]  src_flag;
  logic [`NUM_REQ-1:0]  src_en;
  logic [`NUM_REQ-1:0]  src_prio;
  logic [`NUM_REQ-1:0]  gated;
  logic [`NUM_REQ-1:0]  req_high_next;
  logic [`NUM_REQ-1:0]  req_low_next;
  logic [7:0]           rd_next;
  logic                 preempt_next;
  level_t               level_reg;
  level_t               level_next;

  // Write decode shared by every register.
  logic wr_en_main;
  logic wr_prio_main;
  logic wr_ext_en;
  logic wr_ext_prio;
  logic wr_ext_ctrl;
  logic wr_ext_flags;
  assign wr_en_main   = sfr_wr.wr && (sfr_wr.addr == `ADDR_EN_MAIN);
  assign wr_prio_main = sfr_wr.wr && (sfr_wr.addr == `ADDR_PRIO_MAIN);
  assign wr_ext_en    = sfr_wr.wr && (sfr_wr.addr == `ADDR_EXT_EN);
  assign wr_ext_prio  = sfr_wr.wr && (sfr_wr.addr == `ADDR_EXT_PRIO);
  assign wr_ext_ctrl  = sfr_wr.wr && (sfr_wr.addr == `ADDR_EXT_CTRL);
  assign wr_ext_flags = sfr_wr.wr && (sfr_wr.addr == `ADDR_EXT_FLAGS);

  // Enable and priority storage; bits of absent peripherals are still kept.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      en_main_reg   <= `REG_RESET;
      prio_main_reg <= `REG_RESET;
      ext_en_reg    <= `REG_RESET;
      ext_prio_reg  <= `REG_RESET;
    end
    else
    begin
      if (wr_en_main)
        en_main_reg <= sfr_wr.wdata; // see RULE4
      if (wr_prio_main)
        prio_main_reg <= sfr_wr.wdata;
      if (wr_ext_en)
        ext_en_reg <= sfr_wr.wdata & `EXT_MASK;
      if (wr_ext_prio)
        ext_prio_reg <= sfr_wr.wdata & `EXT_MASK;
    end
  end

  // Resume control: enable bit and sticky flag, hardware set wins over clear.
  // A same-cycle write cannot lose a wakeup: the event is ORed into the value.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      ext_ctrl_reg <= `REG_RESET;
    else if (wr_ext_ctrl)
      ext_ctrl_reg <= (sfr_wr.wdata & `CTRL_MASK) | ({7'h00, resume_req} << `BIT_CTRL_RES_FLAG);
    else if (resume_req)
      ext_ctrl_reg[`BIT_CTRL_RES_FLAG] <= 1'b1;
  end

  // Extended flags: software write first, hardware events then OR in, so an
  // event landing on a clearing write is never lost.
  always_comb
  begin
    ext_flags_next = ext_flags_reg;
    if (wr_ext_flags)
      ext_flags_next = sfr_wr.wdata & `FLAGS_MASK; // see RULE16 see RULE17
    if (pin5_last_reg && !irq_pin5_n)
      ext_flags_next[`BIT_FALL5] = 1'b1; // see RULE12
    if (!pin4_last_reg && irq_pin4)
      ext_flags_next[`BIT_RISE4] = 1'b1; // see RULE13
    if (two_wire_req)
      ext_flags_next[`BIT_TWO_WIRE] = 1'b1; // see RULE14
    if (usb_req)
      ext_flags_next[`BIT_USB] = 1'b1; // see RULE15
  end

  // Pin history starts idle so reset release alone does not fake an edge.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ext_flags_reg <= `REG_RESET;
      pin5_last_reg <= 1'b1;
      pin4_last_reg <= 1'b0;
    end
    else
    begin
      ext_flags_reg <= ext_flags_next;
      pin5_last_reg <= irq_pin5_n;
      pin4_last_reg <= irq_pin4;
    end
  end

  // Source vector: index 0 is resume, then the main sources, then extended.
  assign src_flag = {
    ext_flags_reg[`BIT_FALL5], ext_flags_reg[`BIT_RISE4],
    ext_flags_reg[`BIT_TWO_WIRE], ext_flags_reg[`BIT_USB],
    periph_req.serial1_tx_flag | periph_req.serial1_rx_flag,           // see RULE2
    periph_req.timer2_overflow_flag | periph_req.timer2_external_flag, // see RULE5
    periph_req.serial0_tx_flag | periph_req.serial0_rx_flag,           // see RULE6
    periph_req.timer1_overflow_flag, periph_req.pin1_req,
    periph_req.timer0_overflow_flag, periph_req.pin0_req,
    ext_ctrl_reg[`BIT_CTRL_RES_FLAG]};

  // Enables; absent modules have their gate forced off. Forcing the gate rather
  // than the stored bit keeps readback of absent modules, except serial 1 bits without the extended unit, which read zero.
  assign src_en = {
    EXT_INTR & ext_en_reg[`BIT_EXT_EN_PIN5], EXT_INTR & ext_en_reg[`BIT_EXT_EN_PIN4],
    EXT_INTR & ext_en_reg[`BIT_EXT_EN_TWI],
    EXT_INTR & ext_en_reg[`BIT_EXT_EN_USB], // see RULE18
    EXT_INTR & HAS_SERIAL1 & en_main_reg[`BIT_SERIAL1], // see RULE4
    HAS_TIMER2 & en_main_reg[`BIT_TIMER2],
    HAS_SERIAL0 & en_main_reg[`BIT_SERIAL0],
    en_main_reg[`BIT_TIMER1], en_main_reg[`BIT_PIN1], // see RULE7 see RULE8
    en_main_reg[`BIT_TIMER0], en_main_reg[`BIT_PIN0],
    ext_ctrl_reg[`BIT_CTRL_RES_EN]};

  // Priorities; resume has no priority bit and always sits at the high level.
  assign src_prio = {
    ext_prio_reg[`BIT_EXT_EN_PIN5], ext_prio_reg[`BIT_EXT_EN_PIN4],
    ext_prio_reg[`BIT_EXT_EN_TWI], ext_prio_reg[`BIT_EXT_EN_USB],
    prio_main_reg[`BIT_SERIAL1:`BIT_PIN0], 1'b1};

  // Each source is gated by its own enable and, except resume, the global gate.
  genvar gi;
  generate
    for (gi = 0; gi < `NUM_REQ; gi = gi + 1)
    begin : g_gate
      if (gi == 0)
      begin : g_resume
        assign gated[gi] = src_flag[gi] & src_en[gi]; // see RULE1 see RULE20
      end
      else
      begin : g_norm
        assign gated[gi] = src_flag[gi] & src_en[gi] & en_main_reg[`BIT_GLOBAL]; // see RULE20
      end
      assign req_high_next[gi] = gated[gi] & src_prio[gi];  // see RULE10 see RULE11
      assign req_low_next[gi]  = gated[gi] & ~src_prio[gi]; // see RULE10 see RULE11
    end
  endgenerate

  // Service level tracking; only resume preempts a high-level routine.
  // There is no nesting stack: a return always drops to idle, so a low routine
  // that was preempted is not tracked again at the low level after the return.
  always_comb
  begin
    level_next = level_reg;
    if (return_done)
      level_next = LVL_IDLE;
    else if (enter_high)
      level_next = LVL_HIGH;
    else if (enter_low && level_reg == LVL_IDLE)
      level_next = LVL_LOW;
  end

  // Preemption hint: only a strictly higher request counts, plus resume at the high level.
  always_comb
  begin
    preempt_next = 1'b0;
    unique case (level_reg)
      LVL_IDLE: preempt_next = |gated;
      LVL_LOW:  preempt_next = |req_high_next[`NUM_REQ-1:1] | gated[0]; // see RULE19
      LVL_HIGH: preempt_next = gated[0]; // see RULE19
      default:  preempt_next = 1'b0; // A corrupted level code never preempts.
    endcase
  end

  // Read mux with fixed bits. The result is registered, which costs a cycle of
  // read latency but keeps the decode out of the core's own timing path.
  always_comb
  begin
    rd_next = `REG_RESET;
    unique case (rd_addr)
      `ADDR_EN_MAIN:
        rd_next = {en_main_reg[`BIT_GLOBAL], en_main_reg[`BIT_SERIAL1] & EXT_INTR,
                   en_main_reg[`BIT_TIMER2:`BIT_PIN0]}; // see RULE3
      `ADDR_PRIO_MAIN:
        rd_next = `PRIO_FIXED_ONES | {1'b0, prio_main_reg[`BIT_SERIAL1] & EXT_INTR,
                   prio_main_reg[`BIT_TIMER2:`BIT_PIN0]}; // see RULE3 see RULE9
      `ADDR_EXT_FLAGS:
        rd_next = `FLAGS_FIXED_ONES | ext_flags_reg; // see RULE9
      `ADDR_EXT_CTRL:
        rd_next = `CTRL_FIXED_ONES | ext_ctrl_reg;
      `ADDR_EXT_EN:
        rd_next = `EXT_FIXED_ONES | ext_en_reg;
      `ADDR_EXT_PRIO:
        rd_next = `EXT_FIXED_ONES | ext_prio_reg;
      default:
        rd_next = `REG_RESET;
    endcase
  end

  // Registered requests and hint; requests lag their cause by one cycle.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      req_high    <= '0;
      req_low     <= '0;
      preempt_req <= 1'b0;
    end
    else
    begin
      req_high    <= req_high_next;
      req_low     <= req_low_next;
      preempt_req <= preempt_next;
    end
  end

  // Registered read data; it shows the register addressed one cycle earlier.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rd_data <= `REG_RESET;
    else
      rd_data <= rd_next;
  end

  // Service level register, moved only by the core's entry and return pulses.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      level_reg <= LVL_IDLE;
    else
      level_reg <= level_next;
  end

endmodule

// [dv/core_model.sv]
/* Behavioural processor core that vectors to pending requests.
   Assumes take and leave are one-cycle commands from the bench. */
`timescale 1ns/10ps
module core_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Bench commands and pending requests.
  input  wire logic        take,
  input  wire logic        leave,
  input  wire logic [11:0] req_high,
  input  wire logic [11:0] req_low,
  // Vector entry and return pulses.
  output logic             enter_high,
  output logic             enter_low,
  output logic             return_done
);
  // High level wins, as a real core vectors to the higher request first.
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      enter_high  <= 1'b0;
      enter_low   <= 1'b0;
      return_done <= 1'b0;
    end
    else
    begin
      enter_high  <= take && (|req_high);
      enter_low   <= take && !(|req_high) && (|req_low);
      return_done <= leave;
    end
  end
endmodule

// [dv/irq_ctrl_bench.sv]
/* Self-checking bench for irq_ctrl.
   Assumes core_model stands in for the processor core. */
`timescale 1ns/10ps
module irq_ctrl_bench
  import irq_ctrl_pkg::*;
;
  logic        clk          = 1'b0;
  logic        rst_b        = 1'b0;
  sfr_wr_t     sfr_wr       = '0;
  logic [7:0]  rd_addr      = 8'h00;
  logic [7:0]  rd_data;
  logic [7:0]  rd_data_min;
  periph_req_t periph_req   = '0;
  logic        irq_pin5_n   = 1'b1;
  logic        irq_pin4     = 1'b0;
  logic        two_wire_req = 1'b0;
  logic        usb_req      = 1'b0;
  logic        resume_req   = 1'b0;
  logic        take         = 1'b0;
  logic        leave        = 1'b0;
  logic        enter_high;
  logic        enter_low;
  logic        return_done;
  logic        preempt_req;
  logic [11:0] req_high;
  logic [11:0] req_low;
  logic [11:0] req_high_min;
  logic [11:0] req_low_min;
  int          mismatches   = 0;
  int          tests_run    = 0;
  always #20 clk = ~clk;
  irq_ctrl i_dut (.clk, .rst_b, .sfr_wr, .rd_addr, .rd_data, .periph_req, .irq_pin5_n,
    .irq_pin4, .two_wire_req, .usb_req, .resume_req, .enter_high, .enter_low,
    .return_done, .req_high, .req_low, .preempt_req);
  // Second copy built without the extended unit and the optional peripherals.
  irq_ctrl #(.EXT_INTR(1'b0), .HAS_SERIAL0(1'b0), .HAS_SERIAL1(1'b0), .HAS_TIMER2(1'b0))
    i_dut_min (.clk, .rst_b, .sfr_wr, .rd_addr, .rd_data(rd_data_min), .periph_req,
    .irq_pin5_n, .irq_pin4, .two_wire_req, .usb_req, .resume_req, .enter_high,
    .enter_low, .return_done, .req_high(req_high_min), .req_low(req_low_min),
    .preempt_req());
  core_model i_core (.clk, .rst_b, .take, .leave, .req_high, .req_low, .enter_high,
    .enter_low, .return_done);
  task automatic print_verdict;
    if (mismatches == 0 && tests_run > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Bus helpers leave the bench on a falling edge, so calls chain freely.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    sfr_wr = '{1'b1, a, d};
    @(negedge clk);
    sfr_wr.wr = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk);
    rd_addr = a;
    @(negedge clk);
    chk({4'h0, rd_data}, {4'h0, e});
  endtask
  task automatic req(input logic [11:0] h, input logic [11:0] l);
    @(negedge clk);
    chk(req_high, h);
    chk(req_low, l);
  endtask
  task automatic core(input logic t, input logic l);
    @(negedge clk);
    take = t;
    leave = l;
    @(negedge clk);
    take = 1'b0;
    leave = 1'b0;
  endtask
  // The preempt flag lags the level change, so it gets a bounded wait.
  task automatic wait_pre(input logic e);
    int n = 0;
    while (preempt_req !== e && n < 8)
    begin
      @(negedge clk);
      n++;
    end
    chk({11'h0, preempt_req}, {11'h0, e});
    if (preempt_req !== e)
      print_verdict;
  endtask
  task automatic t_regs;
    logic [7:0] ad [7] = '{8'h91, 8'ha8, 8'hb8, 8'hd8, 8'he8, 8'hf8, 8'h00};
    logic [7:0] rs [7] = '{8'h08, 8'h00, 8'h80, 8'h40, 8'he0, 8'he0, 8'h00};
    logic [7:0] on [7] = '{8'hf8, 8'hff, 8'hff, 8'hf8, 8'hff, 8'hff, 8'h00};
    for (int i = 0; i < 7; i++)
    begin
      rd(ad[i], rs[i]);
      wr(ad[i], 8'hff);
      rd(ad[i], on[i]);
      wr(ad[i], 8'h00);
      rd(ad[i], rs[i]);
    end
  endtask
  task automatic t_gate;
    periph_req = '1;
    for (int i = 0; i < 7; i++)
    begin
      wr(8'ha8, 8'h80 | (8'h01 << i));
      req(12'h000, 12'h001 << (i + 1));
    end
    wr(8'ha8, 8'h7f);
    req(12'h000, 12'h000);
    wr(8'ha8, 8'hff);
    wr(8'hb8, 8'hff);
    req(12'h0fe, 12'h000);
    chk(req_high_min, 12'h01e);
    chk(req_low_min, 12'h000);
    rd(8'ha8, 8'hff);
    chk({4'h0, rd_data_min}, 12'h0bf);
    rd(8'hb8, 8'hff);
    chk({4'h0, rd_data_min}, 12'h0bf);
    wr(8'hb8, 8'h00);
    req(12'h000, 12'h0fe);
    periph_req = '0;
  endtask
  task automatic t_edges;
    wr(8'he8, 8'h1f);
    @(negedge clk);
    rd_addr = 8'h91;
    irq_pin5_n = 1'b0;
    irq_pin4 = 1'b1;
    two_wire_req = 1'b1;
    usb_req = 1'b1;
    @(negedge clk);
    irq_pin4 = 1'b0;
    two_wire_req = 1'b0;
    usb_req = 1'b0;
    rd(8'h91, 8'hf8);
    req(12'h000, 12'hf00);
    wr(8'he8, 8'h1e);
    req(12'h000, 12'he00);
    wr(8'h91, 8'h00);
    irq_pin5_n = 1'b1;
    rd(8'h91, 8'h08);
    req(12'h000, 12'h000);
    wr(8'h91, 8'hf0);
    req(12'h000, 12'he00);
    wr(8'h91, 8'h00);
  endtask
  task automatic t_levels;
    wr(8'ha8, 8'h00);
    wr(8'hd8, 8'h20);
    @(negedge clk);
    resume_req = 1'b1;
    @(negedge clk);
    resume_req = 1'b0;
    req(12'h001, 12'h000);
    wr(8'hd8, 8'h00);
    wr(8'ha8, 8'h81);
    periph_req.pin0_req = 1'b1;
    wait_pre(1'b1);
    core(1'b1, 1'b0);
    wait_pre(1'b0);
    wr(8'hb8, 8'h01);
    wait_pre(1'b1);
    core(1'b1, 1'b0);
    wait_pre(1'b0);
    wr(8'hd8, 8'h30);
    wait_pre(1'b1);
    wr(8'hd8, 8'h00);
    core(1'b0, 1'b1);
    periph_req = '0;
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    t_regs;
    t_gate;
    t_edges;
    t_levels;
    print_verdict;
  end
endmodule

// [dv/irq_ctrl_properties.sv]
/* Port assertions for irq_ctrl.
   Assumes it is bound to every irq_ctrl instance. */
`timescale 1ns/10ps
module irq_ctrl_properties
  import irq_ctrl_pkg::*;
(
  // Clock and reset.
  input wire logic        clk,
  input wire logic        rst_b,
  // Watched ports.
  input wire sfr_wr_t     sfr_wr,
  input wire logic [7:0]  rd_addr,
  input wire logic [7:0]  rd_data,
  input wire logic        irq_pin5_n,
  input wire logic        irq_pin4,
  input wire logic        usb_req,
  input wire logic [11:0] req_high,
  input wire logic [11:0] req_low
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic w91;
  logic wa8;
  // Decoded write strobes keep the properties short.
  assign w91 = sfr_wr.wr && sfr_wr.addr == 8'h91;
  assign wa8 = sfr_wr.wr && sfr_wr.addr == 8'ha8;
  AST_PRIO_TOP: assert property (
    rd_addr == 8'hb8 |=> rd_data[7]) else $error("priority top bit not one");
  AST_FLAGS_LOW: assert property (
    rd_addr == 8'h91 |=> rd_data[3:0] == 4'h8) else $error("flag low nibble wrong");
  AST_EXT_FIXED: assert property (
    rd_addr inside {8'he8, 8'hf8} |=> rd_data[7:5] == 3'b111) else $error("ext top bits");
  AST_ONE_LEVEL: assert property (
    (req_high & req_low) == 12'h000) else $error("request at both levels");
  AST_GLOBAL_MASK: assert property (
    wa8 && !sfr_wr.wdata[7] ##1 !wa8 |=> (req_high[11:1] | req_low[11:1]) == 11'h000)
    else $error("request passed with global gate low");
  AST_PIN5_FALL: assert property (
    $fell(irq_pin5_n) ##1 rd_addr == 8'h91 |=> rd_data[7]) else $error("pin5 flag not set");
  AST_PIN4_RISE: assert property (
    $rose(irq_pin4) ##1 rd_addr == 8'h91 |=> rd_data[6]) else $error("pin4 flag not set");
  AST_USB_SET: assert property (
    usb_req ##1 rd_addr == 8'h91 |=> rd_data[4]) else $error("usb flag not set");
  // Flags may only drop after a write to the flag register.
  AST_FLAGS_HOLD: assert property (
    rd_addr == 8'h91 && $past(rd_addr) == 8'h91 && !$past(w91)
    |=> (rd_data[7:4] & $past(rd_data[7:4])) == $past(rd_data[7:4]))
    else $error("flag cleared by hardware");
endmodule

bind irq_ctrl irq_ctrl_properties i_props (.clk, .rst_b, .sfr_wr, .rd_addr, .rd_data,
  .irq_pin5_n, .irq_pin4, .usb_req, .req_high, .req_low);

// [pkg/irq_ctrl_params.svh]
/*
  Register addresses, bit positions and reset values for the interrupt enable,
  priority and flag logic. Assumes an 8-bit special register space.
*/
`ifndef IRQ_CTRL_PARAMS_SVH
`define IRQ_CTRL_PARAMS_SVH
`define ADDR_EXT_FLAGS    8'h91
`define ADDR_EN_MAIN      8'ha8
`define ADDR_PRIO_MAIN    8'hb8
`define ADDR_EXT_CTRL     8'hd8
`define ADDR_EXT_EN       8'he8
`define ADDR_EXT_PRIO     8'hf8
`define BIT_GLOBAL        7
`define BIT_SERIAL1       6
`define BIT_TIMER2        5
`define BIT_SERIAL0       4
`define BIT_TIMER1        3
`define BIT_PIN1          2
`define BIT_TIMER0        1
`define BIT_PIN0          0
`define BIT_FALL5         7
`define BIT_RISE4         6
`define BIT_TWO_WIRE      5
`define BIT_USB           4
`define BIT_EXT_EN_PIN5   3
`define BIT_EXT_EN_PIN4   2
`define BIT_EXT_EN_TWI    1
`define BIT_EXT_EN_USB    0
`define BIT_CTRL_RES_EN   5
`define BIT_CTRL_RES_FLAG 4
`define PRIO_FIXED_ONES   8'h80
`define FLAGS_FIXED_ONES  8'h08
`define FLAGS_MASK        8'hf0
`define CTRL_FIXED_ONES   8'h40
`define CTRL_MASK         8'hb8
`define EXT_FIXED_ONES    8'he0
`define EXT_MASK          8'h1f
`define REG_RESET         8'h00
`define NUM_REQ           12
`endif

// [pkg/irq_ctrl_pkg.sv]
/*
  Types shared by the interrupt enable, priority and flag logic.
  Assumes the constants header is included alongside.
*/
package irq_ctrl_pkg;
  // Level requests raised by peripherals that own their own flags.
  typedef struct packed {
    logic serial1_tx_flag;
    logic serial1_rx_flag;
    logic timer2_overflow_flag;
    logic timer2_external_flag;
    logic serial0_tx_flag;
    logic serial0_rx_flag;
    logic timer1_overflow_flag;
    logic pin1_req;
    logic timer0_overflow_flag;
    logic pin0_req;
  } periph_req_t;

  // Special register bus access from the core.
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_wr_t;
endpackage
